/* src/aerc_control.sv */
/*
 * converter enable, recovery, disable latency, soft reset and freeze/wait
 * halting, with conversion_control_0 and status registers on avalon-mm.
 * assumes conv_trigger, freeze_mode, wait_mode and severe_error are
 * synchronous to ref_clk; the bus master holds a request until waitrequest low.
 */
// Behaviour
// RULE1: enable, reset, halt selects always writable
// RULE2: flow config bits locked while enabled, unless special
// RULE3: bit 15 enables converter and analog front end
// RULE4: disabling aborts sequence, discards pending results
// RULE5: re-enable waits for disable latency to finish
// RULE6: software waits recovery time before first trigger
// RULE7: soft reset clears flags, indices, list selects
// RULE8: severe error stops converter until soft reset
// RULE9: soft reset bit sticky, hardware clears when done
// RULE10: bit 13 freeze halts at conversion boundary
// RULE11: bit 12 wait halts at conversion boundary
// RULE12: bit 8 selects restart or trigger flow
// RULE13: bits 11:10 select flow register access path
// RULE14: soft reset reads one, blocks triggers meanwhile
`timescale 1ns/1ns
`default_nettype none
module aerc_control #(
    parameter int DISABLE_CYC = aerc_pkg::DISABLE_CYC,
    parameter int RECOVERY_CYC = aerc_pkg::RECOVERY_CYC,
    parameter int SOFT_RESET_CYC = aerc_pkg::SOFT_RESET_CYC,
    parameter int CONV_CYC = aerc_pkg::CONV_CYC,
    parameter int LIST_LEN = aerc_pkg::LIST_LEN
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic conv_trigger,
    input wire logic freeze_mode,
    input wire logic wait_mode,
    input wire logic severe_error,
    output logic analog_enable,
    output logic conv_busy,
    output logic result_store,
    output logic result_discard,
    output logic [aerc_pkg::INDEX_W-1:0] cmd_index,
    output logic [aerc_pkg::INDEX_W-1:0] result_index,
    output logic command_list_select,
    output logic result_list_select,
    output logic flow_mode_select,
    output logic abort_result_store,
    output logic [1:0] flow_reg_access_path,
    output logic converter_soft_reset,
    output logic irq
);
    localparam int TW = aerc_pkg::TIMER_W;
    localparam int IW = aerc_pkg::INDEX_W;
    localparam int NE = aerc_pkg::EV_COUNT;

    if (DISABLE_CYC < 2 || RECOVERY_CYC < 2 || SOFT_RESET_CYC < 2 || CONV_CYC < 2 ||
        DISABLE_CYC > 2 ** TW || RECOVERY_CYC > 2 ** TW || SOFT_RESET_CYC > 2 ** TW ||
        CONV_CYC > 2 ** TW) begin : g_bad_time
        $error("aerc_control: cycle count outside timer range");
    end
    if (LIST_LEN < 2 || LIST_LEN > 2 ** IW) begin : g_bad_list
        $error("aerc_control: list length outside index range");
    end

    typedef struct packed {
        aerc_pkg::aerc_state_type state;
        logic [15:0] ctrl;
        logic sma;
        logic overrun;
        logic error;
        logic cmd_sel;
        logic res_sel;
        logic [IW-1:0] cmd_idx;
        logic [IW-1:0] res_idx;
        logic analog_en;
        logic busy;
        logic store;
        logic discard;
        logic waitreq;
        logic [31:0] rdata;
    } aerc_core_type;

    aerc_core_type st_reg;
    aerc_core_type st_next;

    logic [NE-1:0] events;
    logic [NE-1:0] irq_status;
    logic [NE-1:0] irq_enable;
    logic tmr_load;
    logic [TW-1:0] tmr_value;
    logic tmr_done;
    logic wr_take;
    logic ctrl_wr_hi;
    logic halt_cond;
    logic sr_req;

    // a write takes effect on the edge that sees waitrequest low
    assign wr_take = avs_write && !st_reg.waitreq;
    assign ctrl_wr_hi = wr_take && avs_address == aerc_pkg::CTRL_OFFSET && avs_byteenable[1];
    assign halt_cond = (freeze_mode && st_reg.ctrl[aerc_pkg::FRZ_BIT]) // RULE10
        || (wait_mode && st_reg.ctrl[aerc_pkg::WAIT_BIT]); // RULE11

    aerc_timer #(
        .W(TW)
    ) u_timer (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .load(tmr_load),
        .load_value(tmr_value),
        .done(tmr_done)
    );

    aerc_irq #(
        .N(NE)
    ) u_irq (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .event_in(events),
        .clear_we(wr_take && avs_address == aerc_pkg::IRQ_CLEAR_OFFSET && avs_byteenable[0]),
        .clear_mask(avs_writedata[NE-1:0]),
        .enable_we(wr_take && avs_address == aerc_pkg::IRQ_ENABLE_OFFSET && avs_byteenable[0]),
        .enable_value(avs_writedata[NE-1:0]),
        .status(irq_status),
        .enable(irq_enable),
        .irq(irq)
    );

    always_comb begin
        st_next = st_reg;
        events = '0;
        tmr_load = 1'h0;
        tmr_value = '0;
        st_next.store = 1'h0;
        st_next.discard = 1'h0;
        // one wait cycle per request, then the answer
        st_next.waitreq = !((avs_read || avs_write) && st_reg.waitreq);

        if (ctrl_wr_hi) begin
            st_next.ctrl[aerc_pkg::EN_BIT] = avs_writedata[aerc_pkg::EN_BIT]; // RULE1
            st_next.ctrl[aerc_pkg::FRZ_BIT] = avs_writedata[aerc_pkg::FRZ_BIT]; // RULE1
            st_next.ctrl[aerc_pkg::WAIT_BIT] = avs_writedata[aerc_pkg::WAIT_BIT]; // RULE1
            // a written zero never cancels a running soft reset
            if (avs_writedata[aerc_pkg::SR_BIT]) begin
                st_next.ctrl[aerc_pkg::SR_BIT] = 1'h1; // RULE9
            end
            if (!st_reg.ctrl[aerc_pkg::EN_BIT] || st_reg.sma) begin
                st_next.ctrl[aerc_pkg::PATH_LSB+:2] = avs_writedata[aerc_pkg::PATH_LSB+:2]; // RULE2
                st_next.ctrl[aerc_pkg::STORE_BIT] = avs_writedata[aerc_pkg::STORE_BIT]; // RULE2
                st_next.ctrl[aerc_pkg::FLOW_BIT] = avs_writedata[aerc_pkg::FLOW_BIT]; // RULE2
            end
        end
        if (wr_take && avs_address == aerc_pkg::AUX_CTRL_OFFSET && avs_byteenable[0]) begin
            st_next.sma = avs_writedata[0];
        end

        if (avs_read && st_reg.waitreq) begin
            case (avs_address)
                aerc_pkg::CTRL_OFFSET: st_next.rdata = {16'h0000, st_reg.ctrl};
                aerc_pkg::IRQ_STATUS_OFFSET: st_next.rdata = {{(32 - NE){1'b0}}, irq_status};
                aerc_pkg::IRQ_ENABLE_OFFSET: st_next.rdata = {{(32 - NE){1'b0}}, irq_enable};
                aerc_pkg::ENGINE_STATUS_OFFSET: st_next.rdata = {7'h00, st_reg.analog_en,
                    2'h0, st_reg.res_idx, 2'h0, st_reg.cmd_idx, 1'h0, st_reg.res_sel,
                    st_reg.cmd_sel, st_reg.error, st_reg.overrun, st_reg.state};
                aerc_pkg::AUX_CTRL_OFFSET: st_next.rdata = {31'h00000000, st_reg.sma};
                default: st_next.rdata = 32'h00000000;
            endcase
        end

        sr_req = st_next.ctrl[aerc_pkg::SR_BIT];
        case (st_reg.state)
            aerc_pkg::ST_IDLE: begin
                if (st_reg.ctrl[aerc_pkg::EN_BIT] && !sr_req) begin
                    st_next.state = aerc_pkg::ST_RECOVER;
                    tmr_load = 1'h1;
                    tmr_value = TW'(RECOVERY_CYC - 1);
                end
            end
            aerc_pkg::ST_RECOVER: begin
                if (!st_reg.ctrl[aerc_pkg::EN_BIT]) begin
                    st_next.state = aerc_pkg::ST_DISABLING;
                    tmr_load = 1'h1;
                    tmr_value = TW'(DISABLE_CYC - 1);
                end else begin
                    // triggers before recovery ends are dropped and reported
                    events[aerc_pkg::EV_EARLY_TRIG] = conv_trigger; // RULE6
                    if (tmr_done) begin
                        st_next.state = aerc_pkg::ST_READY;
                    end
                end
            end
            aerc_pkg::ST_READY: begin
                if (!st_reg.ctrl[aerc_pkg::EN_BIT]) begin
                    st_next.state = aerc_pkg::ST_DISABLING;
                    tmr_load = 1'h1;
                    tmr_value = TW'(DISABLE_CYC - 1);
                end else if (halt_cond) begin
                    st_next.state = aerc_pkg::ST_HALTED;
                end else if (conv_trigger && !sr_req) begin // RULE14
                    st_next.state = aerc_pkg::ST_CONVERT;
                    tmr_load = 1'h1;
                    tmr_value = TW'(CONV_CYC - 1);
                end
            end
            aerc_pkg::ST_CONVERT: begin
                if (!st_reg.ctrl[aerc_pkg::EN_BIT]) begin
                    st_next.state = aerc_pkg::ST_DISABLING;
                    st_next.discard = 1'h1; // RULE4
                    tmr_load = 1'h1;
                    tmr_value = TW'(DISABLE_CYC - 1);
                end else begin
                    if (conv_trigger) begin
                        st_next.overrun = 1'h1;
                        events[aerc_pkg::EV_OVERRUN] = 1'h1;
                    end
                    if (tmr_done) begin
                        st_next.store = 1'h1;
                        events[aerc_pkg::EV_DONE] = 1'h1;
                        if (st_reg.cmd_idx == IW'(LIST_LEN - 1)) begin
                            st_next.cmd_idx = '0;
                            st_next.res_idx = '0;
                            st_next.cmd_sel = !st_reg.cmd_sel;
                            st_next.res_sel = !st_reg.res_sel;
                        end else begin
                            st_next.cmd_idx = st_reg.cmd_idx + 1'b1;
                            st_next.res_idx = st_reg.res_idx + 1'b1;
                        end
                        // a halt takes hold here at the boundary, or in ST_READY before a trigger starts
                        st_next.state = halt_cond ? aerc_pkg::ST_HALTED : aerc_pkg::ST_READY;
                    end
                end
            end
            aerc_pkg::ST_HALTED: begin
                if (!st_reg.ctrl[aerc_pkg::EN_BIT]) begin
                    st_next.state = aerc_pkg::ST_DISABLING;
                    tmr_load = 1'h1;
                    tmr_value = TW'(DISABLE_CYC - 1);
                end else if (!halt_cond) begin
                    st_next.state = aerc_pkg::ST_READY;
                end
            end
            aerc_pkg::ST_STOPPED: begin
                st_next.state = aerc_pkg::ST_STOPPED; // RULE8
            end
            aerc_pkg::ST_DISABLING: begin
                if (tmr_done) begin
                    st_next.state = aerc_pkg::ST_IDLE; // RULE5
                    events[aerc_pkg::EV_DIS_DONE] = 1'h1;
                end
            end
            aerc_pkg::ST_SOFTRST: begin
                st_next.cmd_idx = '0; // RULE7
                st_next.res_idx = '0;
                st_next.cmd_sel = 1'h0;
                st_next.res_sel = 1'h0;
                st_next.overrun = 1'h0;
                st_next.error = 1'h0;
                if (tmr_done) begin
                    st_next.state = aerc_pkg::ST_IDLE;
                    st_next.ctrl[aerc_pkg::SR_BIT] = 1'h0; // RULE9
                    events[aerc_pkg::EV_SR_DONE] = 1'h1;
                end
            end
            default: begin
                st_next.state = aerc_pkg::ST_IDLE;
            end
        endcase

        if (severe_error && st_reg.state != aerc_pkg::ST_SOFTRST &&
            st_reg.state != aerc_pkg::ST_IDLE && st_reg.state != aerc_pkg::ST_DISABLING) begin
            st_next.error = 1'h1;
            events[aerc_pkg::EV_SEVERE] = 1'h1;
            st_next.state = aerc_pkg::ST_STOPPED; // RULE8
            st_next.store = 1'h0;
        end

        // soft reset wins over every other transition
        if (sr_req && st_reg.state != aerc_pkg::ST_SOFTRST) begin
            st_next.state = aerc_pkg::ST_SOFTRST; // RULE7
            st_next.store = 1'h0;
            st_next.discard = st_reg.state == aerc_pkg::ST_CONVERT;
            tmr_load = 1'h1;
            tmr_value = TW'(SOFT_RESET_CYC - 1);
        end

        st_next.analog_en = st_next.ctrl[aerc_pkg::EN_BIT] && // RULE3
            (st_next.state == aerc_pkg::ST_RECOVER || st_next.state == aerc_pkg::ST_READY ||
            st_next.state == aerc_pkg::ST_CONVERT || st_next.state == aerc_pkg::ST_HALTED ||
            st_next.state == aerc_pkg::ST_STOPPED);
        st_next.busy = st_next.state == aerc_pkg::ST_CONVERT;
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= '0;
            st_reg.state <= aerc_pkg::ST_IDLE;
            st_reg.ctrl <= aerc_pkg::CTRL_RESET;
            st_reg.sma <= aerc_pkg::AUX_RESET;
            st_reg.waitreq <= 1'h1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign avs_readdata = st_reg.rdata;
    assign avs_waitrequest = st_reg.waitreq;
    assign analog_enable = st_reg.analog_en;
    assign conv_busy = st_reg.busy;
    assign result_store = st_reg.store;
    assign result_discard = st_reg.discard;
    assign cmd_index = st_reg.cmd_idx;
    assign result_index = st_reg.res_idx;
    assign command_list_select = st_reg.cmd_sel;
    assign result_list_select = st_reg.res_sel;
    assign flow_mode_select = st_reg.ctrl[aerc_pkg::FLOW_BIT]; // RULE12
    assign abort_result_store = st_reg.ctrl[aerc_pkg::STORE_BIT];
    assign flow_reg_access_path = st_reg.ctrl[aerc_pkg::PATH_LSB+:2]; // RULE13
    assign converter_soft_reset = st_reg.ctrl[aerc_pkg::SR_BIT]; // RULE14

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    anytime_write_a: assert property (ctrl_wr_hi |=> // RULE1
        st_reg.ctrl[aerc_pkg::EN_BIT] == $past(avs_writedata[aerc_pkg::EN_BIT]) &&
        st_reg.ctrl[aerc_pkg::FRZ_BIT] == $past(avs_writedata[aerc_pkg::FRZ_BIT]))
        else $error("enable or freeze select write lost");
    config_lock_a: assert property (ctrl_wr_hi && st_reg.ctrl[aerc_pkg::EN_BIT] && // RULE2
        !st_reg.sma |=> $stable(st_reg.ctrl[11:8]))
        else $error("locked flow config changed while enabled");
    enable_path_a: assert property (st_reg.state == aerc_pkg::ST_IDLE && // RULE3
        st_reg.ctrl[aerc_pkg::EN_BIT] && !sr_req |=> analog_enable)
        else $error("front end not enabled");
    abort_discard_a: assert property (st_reg.state == aerc_pkg::ST_CONVERT && // RULE4
        !st_reg.ctrl[aerc_pkg::EN_BIT] |=> result_discard && !result_store && !conv_busy)
        else $error("disable did not discard conversion");
    disable_hold_a: assert property ($rose(st_reg.state == aerc_pkg::ST_DISABLING) && // RULE5
        !sr_req |-> (!analog_enable) [*2])
        else $error("front end on during disable latency");
    soft_clear_a: assert property (st_reg.state == aerc_pkg::ST_SOFTRST |=> // RULE7
        cmd_index == '0 && result_index == '0 && !command_list_select &&
        !result_list_select && !st_reg.overrun)
        else $error("soft reset left indices or flags set");
    stopped_hold_a: assert property (st_reg.state == aerc_pkg::ST_STOPPED && // RULE8
        !sr_req |=> st_reg.state == aerc_pkg::ST_STOPPED)
        else $error("converter left stopped state without soft reset");
    sr_release_a: assert property ($fell(converter_soft_reset) |-> // RULE9
        $past(st_reg.state) == aerc_pkg::ST_SOFTRST && $past(tmr_done))
        else $error("soft reset bit cleared before completion");
    boundary_halt_a: assert property (st_reg.state == aerc_pkg::ST_CONVERT && tmr_done && // RULE10
        st_reg.ctrl[aerc_pkg::EN_BIT] && halt_cond && !severe_error && !sr_req |=>
        st_reg.state == aerc_pkg::ST_HALTED && result_store)
        else $error("halt not taken at conversion boundary");
    trig_block_a: assert property (converter_soft_reset |=> !conv_busy) // RULE14
        else $error("conversion started during soft reset");

    soft_reset_done_c: cover property (st_reg.state == aerc_pkg::ST_SOFTRST ##1
        !converter_soft_reset);
    conversion_store_c: cover property (conv_busy ##1 result_store);
    halted_c: cover property (st_reg.state == aerc_pkg::ST_HALTED);
    abort_c: cover property (result_discard ##1 st_reg.state == aerc_pkg::ST_DISABLING);
endmodule // aerc_control
`default_nettype wire

/* src/aerc_pkg.sv */
/*
 * constants, register map and state encoding of the converter enable and
 * soft reset control block.
 * assumes a 20 mhz ref_clk and a 32-bit avalon-mm register bus.
 */
package aerc_pkg;
    // register byte offsets
    localparam logic [5:0] CTRL_OFFSET = 6'h00;
    localparam logic [5:0] IRQ_STATUS_OFFSET = 6'h04;
    localparam logic [5:0] IRQ_CLEAR_OFFSET = 6'h08;
    localparam logic [5:0] IRQ_ENABLE_OFFSET = 6'h0c;
    localparam logic [5:0] ENGINE_STATUS_OFFSET = 6'h10;
    localparam logic [5:0] AUX_CTRL_OFFSET = 6'h14;

    // conversion_control_0 fields
    localparam int EN_BIT = 15;
    localparam int SR_BIT = 14;
    localparam int FRZ_BIT = 13;
    localparam int WAIT_BIT = 12;
    localparam int PATH_LSB = 10;
    localparam int STORE_BIT = 9;
    localparam int FLOW_BIT = 8;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic AUX_RESET = 1'h0;

    // flow_reg_access_path encodings
    localparam logic [1:0] PATH_NONE = 2'h0;
    localparam logic [1:0] PATH_INTERNAL = 2'h1;
    localparam logic [1:0] PATH_BUS = 2'h2;
    localparam logic [1:0] PATH_DUAL = 2'h3;

    // event bits of the interrupt status register
    localparam int EV_DONE = 0;
    localparam int EV_OVERRUN = 1;
    localparam int EV_SEVERE = 2;
    localparam int EV_SR_DONE = 3;
    localparam int EV_DIS_DONE = 4;
    localparam int EV_EARLY_TRIG = 5;
    localparam int EV_COUNT = 6;

    // timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int DISABLE_NS = 1000;
    localparam int RECOVERY_NS = 2000;
    localparam int DISABLE_CYC = DISABLE_NS / CLK_PERIOD_NS;
    localparam int RECOVERY_CYC = (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SOFT_RESET_CYC = 4;
    localparam int CONV_CYC = 14;
    localparam int TIMER_W = 8;

    localparam int INDEX_W = 6;
    localparam int LIST_LEN = 64;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_RECOVER = 3'h1,
        ST_READY = 3'h3,
        ST_CONVERT = 3'h2,
        ST_HALTED = 3'h6,
        ST_DISABLING = 3'h7,
        ST_SOFTRST = 3'h5,
        ST_STOPPED = 3'h4
    } aerc_state_type;
endpackage

/* src/aerc_timer.sv */
/*
 * one-shot down counter; done pulses once, load_value cycles after load.
 * assumes load is a single-cycle request from the owning state machine.
 */
`timescale 1ns/1ns
`default_nettype none
module aerc_timer #(
    parameter int W = aerc_pkg::TIMER_W
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic load,
    input wire logic [W-1:0] load_value,
    output logic done
);
    if (W < 2) begin : g_bad_width
        $error("aerc_timer: width too small");
    end

    typedef struct packed {
        logic [W-1:0] count;
        logic done;
    } aerc_timer_type;

    aerc_timer_type st_reg;
    aerc_timer_type st_next;

    always_comb begin
        st_next = st_reg;
        st_next.done = 1'h0;
        if (load) begin
            st_next.count = load_value;
        end else if (st_reg.count != '0) begin
            st_next.count = st_reg.count - 1'b1;
            st_next.done = (st_reg.count == W'(1));
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign done = st_reg.done;
endmodule // aerc_timer
`default_nettype wire

/* src/aerc_irq.sv */
/*
 * sticky event status, enable mask, write-one-to-clear and level interrupt.
 * assumes event pulses and bus strobes are synchronous to ref_clk.
 */
`timescale 1ns/1ns
`default_nettype none
module aerc_irq #(
    parameter int N = aerc_pkg::EV_COUNT
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [N-1:0] event_in,
    input wire logic clear_we,
    input wire logic [N-1:0] clear_mask,
    input wire logic enable_we,
    input wire logic [N-1:0] enable_value,
    output logic [N-1:0] status,
    output logic [N-1:0] enable,
    output logic irq
);
    if (N < 1 || N > 32) begin : g_bad_count
        $error("aerc_irq: event count out of range");
    end

    typedef struct packed {
        logic [N-1:0] status;
        logic [N-1:0] enable;
        logic irq;
    } aerc_irq_type;

    aerc_irq_type st_reg;
    aerc_irq_type st_next;

    always_comb begin
        st_next = st_reg;
        // a new event in the clearing cycle survives the clear
        for (int i = 0; i < N; i++) begin
            st_next.status[i] = (st_reg.status[i] & ~(clear_we & clear_mask[i])) | event_in[i];
        end
        if (enable_we) begin
            st_next.enable = enable_value;
        end
        st_next.irq = |(st_next.status & st_next.enable);
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign status = st_reg.status;
    assign enable = st_reg.enable;
    assign irq = st_reg.irq;
endmodule // aerc_irq
`default_nettype wire

/* verification/aerc_control_tb_top.sv */
/* bench of aerc_control: register locks, enable, abort, soft reset, halts, irq.
   assumes aerc_pkg and the design modules are compiled first. */
`timescale 1ns/1ns
`default_nettype none
module aerc_control_tb_top;
    localparam int CONV = 12;
    logic ref_clk = 0, rst_b = 0, avs_read = 0, avs_write = 0, conv_trigger = 0;
    logic freeze_mode = 0, wait_mode = 0, severe_error = 0;
    logic [5:0] avs_address = 0;
    logic [31:0] avs_writedata = 0, avs_readdata, rdata, d;
    logic avs_waitrequest, analog_enable, conv_busy, result_store, result_discard, irq;
    logic [5:0] cmd_index, result_index;
    logic flow_mode_select, abort_result_store, converter_soft_reset;
    logic [1:0] flow_reg_access_path;
    int fail_count = 0, comparisons = 0, cyc = 0, n_store = 0, n_disc = 0, i;
    aerc_control #(.DISABLE_CYC(3), .RECOVERY_CYC(8), .SOFT_RESET_CYC(20),
        .CONV_CYC(CONV), .LIST_LEN(64)) aerc_control_i (.ref_clk(ref_clk), .rst_b(rst_b),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .conv_trigger(conv_trigger),
        .freeze_mode(freeze_mode), .wait_mode(wait_mode), .severe_error(severe_error),
        .analog_enable(analog_enable), .conv_busy(conv_busy), .result_store(result_store),
        .result_discard(result_discard), .cmd_index(cmd_index), .result_index(result_index),
        .command_list_select(), .result_list_select(), .flow_mode_select(flow_mode_select),
        .abort_result_store(abort_result_store), .flow_reg_access_path(flow_reg_access_path),
        .converter_soft_reset(converter_soft_reset), .irq(irq));
    always #25 ref_clk = ~ref_clk;
    // pulses counted mid-cycle, where the registered outputs are settled
    always @(negedge ref_clk) begin
        n_store += (result_store === 1'b1);
        n_disc += (result_discard === 1'b1);
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc > 20000) begin
            fail_count++;
            summarize();
        end
    end
    task summarize();
        if (fail_count == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // request held until an edge samples waitrequest low; data taken at that edge
    task bus(input logic w, input logic [5:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= v;
        avs_write <= w;
        avs_read <= !w;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        rdata = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task pulse_trig();
        @(posedge ref_clk);
        conv_trigger <= 1'b1;
        @(posedge ref_clk);
        conv_trigger <= 1'b0;
    endtask
    task st(input logic [2:0] s);
        for (i = 0; i < 40; i++) begin
            bus(0, 6'h10, 0);
            if (rdata[2:0] === s) break;
        end
        chk(rdata[2:0], s);
    endtask
    initial begin
        void'($urandom(32'hd663));
        repeat (10) @(posedge ref_clk);
        rst_b <= 1'b1;
        bus(0, 6'h00, 0); chk(rdata, 32'h0);
        bus(0, 6'h3c, 0); chk(rdata, 32'h0);
        bus(1, 6'h0c, 32'h3f);
        bus(1, 6'h00, 32'h0f00); bus(0, 6'h00, 0); chk(rdata, 32'h0f00);
        bus(1, 6'h00, 32'h8f00);
        pulse_trig();
        st(3'h3);
        bus(0, 6'h04, 0); chk(rdata & 32'h20, 32'h20);
        chk(irq, 1'b1);
        bus(0, 6'h00, 0); chk(rdata, 32'h8f00);
        chk({flow_reg_access_path, abort_result_store, flow_mode_select}, 32'hf);
        chk(analog_enable, 1'b1);
        repeat (3) begin
            d = $urandom;
            bus(1, 6'h00, {16'h0, 2'b10, d[13:12], 12'h000});
            bus(0, 6'h00, 0); chk(rdata, 32'h8f00 | (d & 32'h3000));
        end
        bus(1, 6'h00, 32'h8000);
        pulse_trig();
        @(negedge ref_clk); chk(conv_busy, 1'b1);
        repeat (CONV + 2) @(posedge ref_clk);
        chk(n_store, 1); chk(cmd_index, 6'h01);
        chk(result_index, 6'h01);
        pulse_trig();
        bus(1, 6'h00, 32'h0000);
        repeat (3) @(posedge ref_clk);
        chk(n_disc, 1); chk(n_store, 1); chk(analog_enable, 1'b0);
        st(3'h0);
        bus(0, 6'h04, 0); chk(rdata & 32'h10, 32'h10);
        bus(1, 6'h00, 32'h8000);
        st(3'h3);
        @(posedge ref_clk) severe_error <= 1'b1;
        @(posedge ref_clk) severe_error <= 1'b0;
        st(3'h4);
        pulse_trig();
        @(negedge ref_clk); chk(conv_busy, 1'b0);
        bus(1, 6'h00, 32'hc000);
        bus(0, 6'h00, 0); chk(rdata & 32'h4000, 32'h4000);
        chk(converter_soft_reset, 1'b1);
        bus(1, 6'h00, 32'h8000);
        bus(0, 6'h00, 0); chk(rdata & 32'h4000, 32'h4000);
        st(3'h3);
        chk(rdata & 32'h003f3f78, 32'h0);
        bus(0, 6'h00, 0); chk(rdata, 32'h8000);
        chk(converter_soft_reset, 1'b0);
        chk(result_index, 6'h00);
        bus(1, 6'h08, 32'h3f);
        bus(0, 6'h04, 0); chk(rdata, 32'h0);
        chk(irq, 1'b0);
        // freeze then wait: halt only when both the select bit and the mode are set
        for (int k = 0; k < 2; k++) begin
            freeze_mode <= (k == 0);
            wait_mode <= (k == 1);
            st(3'h3);
            bus(1, 6'h00, (k == 0) ? 32'ha000 : 32'h9000);
            st(3'h6);
            pulse_trig();
            @(negedge ref_clk); chk(conv_busy, 1'b0);
            freeze_mode <= 1'b0;
            wait_mode <= 1'b0;
            st(3'h3);
            bus(1, 6'h00, 32'h8000);
        end
        // freeze entered mid-conversion: the result is kept, then the engine halts
        bus(1, 6'h00, 32'ha000);
        pulse_trig();
        freeze_mode <= 1'b1;
        repeat (CONV + 2) @(posedge ref_clk);
        chk(n_store, 2);
        st(3'h6);
        freeze_mode <= 1'b0;
        st(3'h3);
        summarize();
    end
endmodule // aerc_control_tb_top
`default_nettype wire
